// file: src/diag_defs.svh
// Register indices, field positions, reset values and bus codes
// Behaviour
// R1: Writing the unlock code to the key register opens the three diagnostic registers.
// R2: Without the unlock code held, diagnostic register writes are dropped silently.
// R3: Test-voltage enable connects analog input six to the internal test voltage.
// R4: Test-voltage enable is ignored while decision-walk enable is set.
// R5: Decision-walk enable, bit zero, puts bit decisions into walk mode.
// R6: Low pattern register forces bit positions seven to zero during sampling.
// R7: High pattern register forces bit positions fifteen to eight during sampling.
// R8: With self-check enable clear, pattern registers keep values but have no effect.
// R9: Enable register bits seven to five and three to one read zero, not writable.
`ifndef DIAG_DEFS_SVH
`define DIAG_DEFS_SVH

`define DIAG_ADDR_W        12
`define DIAG_IDX_W         10
`define IDX_UNLOCK_KEY     10'h0BF
`define IDX_MODE_ENABLES   10'h0C0
`define IDX_PATTERN_LOW    10'h0C1
`define IDX_PATTERN_HIGH   10'h0C2

`define UNLOCK_CODE        8'h96
`define RST_UNLOCK_KEY     8'h00
`define RST_MODE_ENABLES   8'h00
`define RST_PATTERN_LOW    8'h00
`define RST_PATTERN_HIGH   8'h00

`define BIT_DECISION_WALK  0
`define BIT_TEST_VOLTAGE   4
`define MODE_WRITE_MASK    8'h11

`define RESP_OKAY          2'h0
`define RESP_DECERR        2'h3

`endif

// file: src/diag_pkg.sv
// State types for the diagnostic unlock block
package diag_pkg;

  typedef enum logic {
    WR_IDLE,
    WR_RESP
  } wr_state_t;

  typedef struct packed {
    logic        have_aw;
    logic        have_w;
    logic        awready;
    logic        wready;
    logic [11:0] addr;
    logic [7:0]  data;
    logic        lane0;
  } join_state_t;

  typedef struct packed {
    logic        test_voltage_connect;
    logic        decision_walk_active;
    logic        self_check_enable;
    logic [15:0] force_pattern;
    logic        force_active;
  } effect_state_t;

  typedef struct packed {
    logic [7:0]  unlock_key;
    logic [7:0]  mode_enables;
    logic [7:0]  pattern_low;
    logic [7:0]  pattern_high;
    wr_state_t   wr_state;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        unlocked;
  } top_state_t;

endpackage

// file: src/axil_write_join.sv
// Joins the AXI4-Lite write address and write data channels into one request
`timescale 1ns/1ps
module axil_write_join (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // Write data channel
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // Joined request
  output logic             req_valid,
  output logic [11:0]      req_addr,
  output logic [7:0]       req_data,
  output logic             req_lane0,
  input  wire logic        req_done
);

  diag_pkg::join_state_t state_reg;
  diag_pkg::join_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (req_done) begin
      state_next.have_aw = 1'b0;
      state_next.have_w  = 1'b0;
    end
    // Either channel may arrive first; each is held until the joined request is served (req_done)
    if (awvalid && state_reg.awready) begin
      state_next.have_aw = 1'b1;
      state_next.addr    = awaddr;
    end
    if (wvalid && state_reg.wready) begin
      state_next.have_w = 1'b1;
      state_next.data   = wdata[7:0];
      state_next.lane0  = wstrb[0];
    end
    state_next.awready = !state_next.have_aw;
    state_next.wready  = !state_next.have_w;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign awready   = state_reg.awready;
  assign wready    = state_reg.wready;
  assign req_valid = state_reg.have_aw && state_reg.have_w;
  assign req_addr  = state_reg.addr;
  assign req_data  = state_reg.data;
  assign req_lane0 = state_reg.lane0;

endmodule

// file: src/diag_effects.sv
// Turns the diagnostic registers into registered controls for the converter
`timescale 1ns/1ps
`include "diag_defs.svh"
module diag_effects (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Register contents
  input  wire logic [7:0]  mode_enables,
  input  wire logic [7:0]  pattern_low,
  input  wire logic [7:0]  pattern_high,
  // Converter phase
  input  wire logic        sampling_phase,
  // Controls
  output logic             test_voltage_connect,
  output logic             decision_walk_active,
  output logic             self_check_enable,
  output logic [15:0]      force_pattern,
  output logic             force_active
);

  diag_pkg::effect_state_t state_reg;
  diag_pkg::effect_state_t state_next;
  logic                    walk;
  logic                    volt;

  always_comb begin
    walk  = mode_enables[`BIT_DECISION_WALK];
    volt  = mode_enables[`BIT_TEST_VOLTAGE];
    state_next = state_reg;
    state_next.decision_walk_active = walk;                 // see R5
    state_next.test_voltage_connect = volt && !walk;        // see R3 see R4
    state_next.self_check_enable    = walk || volt;
    // Pattern reaches the converter only in sampling with self-check on
    state_next.force_active = (walk || volt) && sampling_phase; // see R8
    if (state_next.force_active) begin
      state_next.force_pattern = {pattern_high, pattern_low}; // see R6 see R7
    end else begin
      state_next.force_pattern = 16'h0000;                  // see R8
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign test_voltage_connect = state_reg.test_voltage_connect;
  assign decision_walk_active = state_reg.decision_walk_active;
  assign self_check_enable    = state_reg.self_check_enable;
  assign force_pattern        = state_reg.force_pattern;
  assign force_active         = state_reg.force_active;

endmodule

// file: src/converter_diag_unlock_test.sv
// Diagnostic unlock and test-mode registers behind an AXI4-Lite slave
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "diag_defs.svh"
module converter_diag_unlock_test (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Converter core
  input  wire logic        sampling_phase,
  output logic             test_voltage_connect,
  output logic             decision_walk_active,
  output logic             self_check_enable,
  output logic [15:0]      force_pattern,
  output logic             force_active,
  output logic             diag_unlocked
);

  diag_pkg::top_state_t state_reg;
  diag_pkg::top_state_t state_next;
  logic                 req_valid;
  logic [11:0]          req_addr;
  logic [7:0]           req_data;
  logic                 req_lane0;
  logic                 req_done;
  logic [7:0]           rd_byte;
  logic                 rd_hit;
  logic                 wr_hit;
  logic                 wr_diag;
  logic [`DIAG_IDX_W-1:0] wr_idx;

  // Word index of an aligned byte address; misaligned maps to no register
  function automatic logic [`DIAG_IDX_W-1:0] word_index(
    input logic [11:0] addr
  );
    if (addr[1:0] != 2'h0) begin
      word_index = '1;
    end else begin
      word_index = addr[11:2];
    end
  endfunction

  // True when the index is one of the four mapped registers
  function automatic logic is_mapped(input logic [`DIAG_IDX_W-1:0] idx);
    is_mapped = (idx == `IDX_UNLOCK_KEY) || (idx == `IDX_MODE_ENABLES) ||
                (idx == `IDX_PATTERN_LOW) || (idx == `IDX_PATTERN_HIGH);
  endfunction

  axil_write_join u_join (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .awaddr    (s_axi_awaddr),
    .awvalid   (s_axi_awvalid),
    .awready   (s_axi_awready),
    .wdata     (s_axi_wdata),
    .wstrb     (s_axi_wstrb),
    .wvalid    (s_axi_wvalid),
    .wready    (s_axi_wready),
    .req_valid (req_valid),
    .req_addr  (req_addr),
    .req_data  (req_data),
    .req_lane0 (req_lane0),
    .req_done  (req_done)
  );

  // A joined write is served once the previous response has left
  assign req_done = req_valid && (state_reg.wr_state == diag_pkg::WR_IDLE);

  always_comb begin
    state_next = state_reg;
    wr_idx  = word_index(req_addr);
    wr_hit  = is_mapped(wr_idx);
    wr_diag = (wr_idx == `IDX_MODE_ENABLES) ||
              (wr_idx == `IDX_PATTERN_LOW) ||
              (wr_idx == `IDX_PATTERN_HIGH);
    rd_hit  = is_mapped(word_index(s_axi_araddr));
    rd_byte = 8'h00;

    // Write side
    unique case (state_reg.wr_state)
      diag_pkg::WR_IDLE: begin
        if (req_done) begin
          state_next.wr_state = diag_pkg::WR_RESP;
          state_next.bresp    = wr_hit ? `RESP_OKAY : `RESP_DECERR;
          if (req_lane0 && wr_idx == `IDX_UNLOCK_KEY) begin
            state_next.unlock_key = req_data;                 // see R1
          end
          // Locked writes to the three diagnostic registers complete normally but change nothing
          if (req_lane0 && wr_diag && state_reg.unlocked) begin // see R1 see R2
            unique case (wr_idx)
              `IDX_MODE_ENABLES: begin
                state_next.mode_enables = req_data & `MODE_WRITE_MASK; // see R9
              end
              `IDX_PATTERN_LOW: begin
                state_next.pattern_low = req_data;
              end
              default: begin
                state_next.pattern_high = req_data;
              end
            endcase
          end
        end
      end
      diag_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          state_next.wr_state = diag_pkg::WR_IDLE;
        end
      end
    endcase
    state_next.unlocked = (state_next.unlock_key == `UNLOCK_CODE); // see R1

    // Read side: one outstanding read, answered on the next edge
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid  = 1'b0;
      state_next.arready = 1'b1;
    end
    if (s_axi_arvalid && state_reg.arready) begin
      unique case (word_index(s_axi_araddr))
        `IDX_UNLOCK_KEY:   rd_byte = state_reg.unlock_key;
        `IDX_MODE_ENABLES: rd_byte = state_reg.mode_enables; // see R9
        `IDX_PATTERN_LOW:  rd_byte = state_reg.pattern_low;
        `IDX_PATTERN_HIGH: rd_byte = state_reg.pattern_high;
        default:           rd_byte = 8'h00;
      endcase
      state_next.rvalid  = 1'b1;
      state_next.arready = 1'b0;
      state_next.rdata   = {24'h000000, rd_byte};
      state_next.rresp   = rd_hit ? `RESP_OKAY : `RESP_DECERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg              <= '0;
      state_reg.unlock_key   <= `RST_UNLOCK_KEY;
      state_reg.mode_enables <= `RST_MODE_ENABLES;
      state_reg.pattern_low  <= `RST_PATTERN_LOW;
      state_reg.pattern_high <= `RST_PATTERN_HIGH;
      state_reg.wr_state     <= diag_pkg::WR_IDLE;
      state_reg.arready      <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  diag_effects u_effects (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .mode_enables         (state_reg.mode_enables),
    .pattern_low          (state_reg.pattern_low),
    .pattern_high         (state_reg.pattern_high),
    .sampling_phase       (sampling_phase),
    .test_voltage_connect (test_voltage_connect),
    .decision_walk_active (decision_walk_active),
    .self_check_enable    (self_check_enable),
    .force_pattern        (force_pattern),
    .force_active         (force_active)
  );

  assign s_axi_bvalid  = (state_reg.wr_state == diag_pkg::WR_RESP);
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rdata   = state_reg.rdata;
  assign s_axi_rresp   = state_reg.rresp;
  assign diag_unlocked = state_reg.unlocked;

endmodule

// file: verification/diag_unlock_properties.sv
// Port assertions for the diagnostic unlock block
`timescale 1ns/1ps
module diag_unlock_properties (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Converter controls
  input wire logic        sampling_phase,
  input wire logic        test_voltage_connect,
  input wire logic        decision_walk_active,
  input wire logic        self_check_enable,
  input wire logic [15:0] force_pattern,
  input wire logic        force_active,
  input wire logic        diag_unlocked
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  write_answer_a:
    assert property (write_taken |-> ##[1:4] s_axi_bvalid)
    else $error("write got no response");
  read_answer_a:
    assert property (read_taken |=> s_axi_rvalid)
    else $error("read answer late");
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready
                     |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  unlock_rise_a:
    assert property ($rose(diag_unlocked)
                     |-> $rose(s_axi_bvalid) && s_axi_bresp == 2'h0)
    else $error("unlock without a write");
  locked_hold_a:
    assert property ($changed(decision_walk_active)
                     || $changed(test_voltage_connect)
                     |-> $past(diag_unlocked, 2))
    else $error("mode changed while locked");
  walk_masks_test_a:
    assert property (decision_walk_active |-> !test_voltage_connect)
    else $error("test voltage during walk");
  check_sum_a:
    assert property (self_check_enable
                     == (decision_walk_active || test_voltage_connect))
    else $error("enable summary wrong");
  pattern_quiet_a:
    assert property (!force_active |-> force_pattern == 16'h0000)
    else $error("pattern leaks while idle");
  force_gate_a:
    assert property (force_active |-> self_check_enable)
    else $error("force without enable");
  force_sample_a:
    assert property ($rose(force_active) |-> $past(sampling_phase))
    else $error("force outside sampling");
endmodule

bind converter_diag_unlock_test diag_unlock_properties i_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .sampling_phase,
  .test_voltage_connect, .decision_walk_active, .self_check_enable,
  .force_pattern, .force_active, .diag_unlocked
);

// file: verification/converter_diag_unlock_test_tb.sv
// Self-checking bench for the diagnostic unlock block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module converter_diag_unlock_test_tb;
  localparam logic [11:0] KEY = 12'h2FC;
  localparam logic [11:0] ENA = 12'h300;
  localparam logic [11:0] PLO = 12'h304;
  localparam logic [11:0] PHI = 12'h308;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, sampling_phase;
  logic        test_voltage_connect, decision_walk_active, force_active;
  logic        self_check_enable, diag_unlocked;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] force_pattern;
  int          failures, n_tests;

  converter_diag_unlock_test i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sampling_phase, .test_voltage_connect, .decision_walk_active,
    .self_check_enable, .force_pattern, .force_active, .diag_unlocked
  );

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    logic ah, dh;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    ah = 1'b0;
    dh = 1'b0;
    while (!(ah && dh)) begin
      @(posedge aclk);
      if (!ah && s_axi_awready) begin
        ah = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dh && s_axi_wready) begin
        dh = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    // Response is made to wait one cycle so that it must be held
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    `CHK("bresp", r, s_axi_bresp)
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    `CHK("rdata", {24'h000000, d}, s_axi_rdata)
    `CHK("rresp", r, s_axi_rresp)
  endtask

  // Lets a register write reach the converter controls
  task automatic outs(input logic [3:0] e);
    repeat (3) @(posedge aclk);
    `CHK("controls", e, {diag_unlocked, self_check_enable,
         decision_walk_active, test_voltage_connect})
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial begin
    #20000;
    failures++;
    stop_test;
  end

  initial begin
    failures = 0;
    n_tests = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, sampling_phase} = 3'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h00000000;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++)
      rd(KEY + 12'(4 * i), 8'h00, 2'h0);
    wr(ENA, 8'h11, 2'h0);
    wr(PLO, 8'h5A, 2'h0);
    rd(ENA, 8'h00, 2'h0);
    rd(PLO, 8'h00, 2'h0);
    outs(4'h0);
    wr(KEY, 8'h96, 2'h0);
    rd(KEY, 8'h96, 2'h0);
    outs(4'h8);
    wr(ENA, 8'hFF, 2'h0);
    rd(ENA, 8'h11, 2'h0);
    outs(4'hE);
    wr(ENA, 8'h10, 2'h0);
    outs(4'hD);
    wr(ENA, 8'h01, 2'h0);
    outs(4'hE);
    sampling_phase <= 1'b1;
    wr(PLO, 8'hA5, 2'h0);
    wr(PHI, 8'h3C, 2'h0);
    outs(4'hE);
    `CHK("pattern", 16'h3CA5, force_pattern)
    `CHK("force", 1'b1, force_active)
    sampling_phase <= 1'b0;
    outs(4'hE);
    `CHK("pattern", 16'h0000, force_pattern)
    `CHK("force", 1'b0, force_active)
    sampling_phase <= 1'b1;
    wr(ENA, 8'h00, 2'h0);
    outs(4'h8);
    `CHK("pattern", 16'h0000, force_pattern)
    `CHK("force", 1'b0, force_active)
    rd(PLO, 8'hA5, 2'h0);
    rd(PHI, 8'h3C, 2'h0);
    wr(KEY, 8'h00, 2'h0);
    wr(PLO, 8'h00, 2'h0);
    rd(PLO, 8'hA5, 2'h0);
    wr(ENA, 8'h10, 2'h0);
    rd(ENA, 8'h00, 2'h0);
    outs(4'h0);
    wr(12'h400, 8'h01, 2'h3);
    rd(12'h400, 8'h00, 2'h3);
    wr(12'h301, 8'h01, 2'h3);
    rd(12'h301, 8'h00, 2'h3);
    stop_test;
  end
endmodule
